// ### common/omc_defines.svh
// register offsets, field positions, reset values for the macrocell array
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH

// apb byte offsets, one aligned word each
`define OMC_ARCH_LO_OFS 12'h000
`define OMC_ARCH_HI_OFS 12'h004
`define OMC_OE_MODE_OFS 12'h008
`define OMC_STATE_OFS 12'h00c
`define OMC_PIN_OFS 12'h010

// architecture bit positions inside one macrocell nibble
`define OMC_ARCH_REG_BIT 0
`define OMC_ARCH_POL_BIT 1
`define OMC_ARCH_FBPIN_BIT 2
`define OMC_ARCH_CLKB_BIT 3

// field widths and read field positions
`define OMC_ARCH_W 4
`define OMC_OEM_W 2
`define OMC_HI_FIELD_POS 16

// reset values: combinatorial, true polarity, /q feedback, clock a
`define OMC_ARCH_RST 4'h2
// output enable reset: dedicated input, pins float until configured
`define OMC_OEM_RST 2'h1

`endif

// ### common/omc_pkg.sv
// types and term-size table for the output macrocell array
package omc_pkg;
  `include "omc_defines.svh"

  // number of macrocells in the array
  localparam int OMC_CELLS = 12;
  // total logic product terms over all macrocells
  localparam int OMC_TERMS_TOTAL = 136;

  // output enable choice in combinatorial mode
  typedef enum logic [1:0]
  {
    OMC_OE_ON = 2'h0,
    OMC_OE_OFF = 2'h1,
    OMC_OE_TERM = 2'h2,
    OMC_OE_TERM2 = 2'h3
  } omc_oe_t;

  // four architecture bits of one macrocell
  typedef logic [`OMC_ARCH_W-1:0] omc_arch_t;

  // logic product terms of macrocell i
  function automatic int omc_term_count(input int i);
    int n;
    n = 8;
    if (i == 2 || i == 9)
      n = 10;
    else if (i == 3 || i == 8)
      n = 12;
    else if (i == 4 || i == 7)
      n = 14;
    else if (i == 5 || i == 6)
      n = 16;
    return n;
  endfunction : omc_term_count

  // first bit of macrocell i in the flat product-term vector
  function automatic int omc_term_base(input int i);
    int b;
    b = 0;
    for (int k = 0; k < i; k++)
      b = b + omc_term_count(k);
    return b;
  endfunction : omc_term_base
endpackage : omc_pkg

// ### core/omc_macrocell.sv
// one output macrocell: sum gate, flip-flop, polarity, enable, feedback
`timescale 1ns/1ps
// bit positions are macros; the guard keeps a second include harmless
`include "omc_defines.svh"
module omc_macrocell #(
  parameter int TERMS = 8
) (
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic [TERMS-1:0] terms, // logic product terms
  input wire logic oeTerm, // enable product term
  input wire omc_pkg::omc_arch_t arch, // architecture bits
  input wire omc_pkg::omc_oe_t oeMode, // combinatorial enable mode
  input wire logic edgeA, // rising edge seen on clock input a
  input wire logic edgeB, // rising edge seen on clock input b
  input wire logic asyncClearTerm,
  input wire logic syncSetTerm,
  input wire logic pinSync, // synchronised pin level
  output logic pinOut,
  output logic pinOeN,
  output logic fbTrue,
  output logic fbInv,
  output logic qState
);
  import omc_pkg::*;

  // whole state of the cell
  typedef struct packed {
    logic q;
  } omc_cell_state_t;

  omc_cell_state_t st; // registered state
  omc_cell_state_t next_st; // next state
  logic sumTerm; // or of all logic terms
  logic regMode; // registered mode selected
  logic clkEdge; // edge of the selected clock
  logic qEff; // q after the clear override
  logic pinLevel; // level before polarity
  logic drive; // output buffer enabled
  logic fbSel; // chosen feedback source

  // combinational cell behaviour
  always_comb
  begin
    sumTerm = |terms;
    regMode = arch[`OMC_ARCH_REG_BIT];
    clkEdge = arch[`OMC_ARCH_CLKB_BIT] ? edgeB : edgeA;
    next_st = st;
    if (clkEdge)
    begin
      // preset sampled at the selected clock edge
      if (regMode && syncSetTerm)
        next_st.q = 1'b1;
      else
        next_st.q = sumTerm;
    end
    // clear beats preset and any edge
    if (regMode && asyncClearTerm)
      next_st.q = 1'b0;
    if (sysRst)
      next_st.q = 1'b0;
    // clear shows at once, without waiting for mclk
    qEff = (regMode && asyncClearTerm) ? 1'b0 : st.q;
    // polarity acts after the stored value
    pinLevel = regMode ? qEff : sumTerm;
    pinOut = arch[`OMC_ARCH_POL_BIT] ? pinLevel : ~pinLevel;
    if (regMode)
      drive = oeTerm;
    else if (oeMode == OMC_OE_ON)
      drive = 1'b1;
    else if (oeMode == OMC_OE_OFF)
      drive = 1'b0;
    else
      drive = oeTerm;
    pinOeN = ~drive;
    // pin feedback or inverted q feedback
    fbSel = arch[`OMC_ARCH_FBPIN_BIT] ? pinSync : ~qEff;
    fbTrue = fbSel;
    fbInv = ~fbSel;
    qState = qEff;
  end

  // state register
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end
endmodule : omc_macrocell

// ### core/omc_macrocell_array.sv
// twelve output macrocells with apb configuration and readback
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// offsets and reset values are macros; the guard keeps a second include safe
`include "omc_defines.svh"
module omc_macrocell_array #(
  parameter int CELLS = 12,
  parameter int TERMS_TOTAL = 136
) (
  input wire logic mclk,
  input wire logic sysRst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock pins, sampled on mclk
  input wire logic clockInputA,
  input wire logic clockInputB,
  // and-array side
  input wire logic [TERMS_TOTAL-1:0] productTerms,
  input wire logic [CELLS-1:0] oeTerms,
  input wire logic asyncClearTerm,
  input wire logic syncSetTerm,
  output logic [CELLS-1:0] fbTrue,
  output logic [CELLS-1:0] fbInv,
  // io pins
  input wire logic [CELLS-1:0] pinIn,
  output logic [CELLS-1:0] pinOut,
  output logic [CELLS-1:0] pinOeN
);
  import omc_pkg::*;

  // sizes of the configuration words
  localparam int ARCH_BITS = CELLS * `OMC_ARCH_W;
  localparam int OEM_BITS = CELLS * `OMC_OEM_W;
  localparam int LO_BITS = 32;
  localparam int HI_BITS = ARCH_BITS - LO_BITS;

  // whole state of the array top
  typedef struct packed {
    logic [ARCH_BITS-1:0] archBits; // four bits per cell
    logic [OEM_BITS-1:0] oeBits; // two bits per cell
    logic [1:0] clkASync; // two-stage sync of clock a
    logic [1:0] clkBSync; // two-stage sync of clock b
    logic clkAPrev; // previous synced clock a
    logic clkBPrev; // previous synced clock b
    logic [CELLS-1:0] pinMeta; // first pin sync stage
    logic [CELLS-1:0] pinSync; // second pin sync stage
    logic [31:0] rdata; // read data held for access phase
    logic slvErr; // error held for access phase
  } omc_array_state_t;

  omc_array_state_t st; // registered state
  omc_array_state_t next_st; // next state

  logic edgeA; // rising edge on synced clock a
  logic edgeB; // rising edge on synced clock b
  logic [CELLS-1:0] qState; // stored flip-flop values
  logic [CELLS-1:0] cellPinOut; // pin levels from cells
  logic [CELLS-1:0] cellOeN; // enables from cells
  logic setupPhase; // apb setup cycle
  logic accessWrite; // apb write taking effect
  logic [31:0] readWord; // decoded read value
  logic readErr; // unmapped address seen
  logic [31:0] archLoWord; // low architecture word
  logic [31:0] archHiWord; // high architecture word
  logic [31:0] oeWord; // output enable word

  // merge write data into a word under the byte strobes
  function automatic logic [31:0] mergeWord(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = oldWord;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = newWord[b*8 +: 8];
    end
    return res;
  endfunction : mergeWord

  // clock edges come from the second and third stages only,
  // so the metastable first stage feeds nothing but the second
  assign edgeA = st.clkASync[1] & ~st.clkAPrev;
  assign edgeB = st.clkBSync[1] & ~st.clkBPrev;

  // the slave never waits; every access ends in its first access cycle
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.slvErr;
  assign pinOut = cellPinOut;
  assign pinOeN = cellOeN;

  // apb phase decode
  assign setupPhase = psel & ~penable;
  assign accessWrite = psel & penable & pwrite;

  // configuration words as software sees them, upper bits zero
  always_comb
  begin
    archLoWord = st.archBits[LO_BITS-1:0];
    archHiWord = 32'h0000_0000;
    archHiWord[HI_BITS-1:0] = st.archBits[ARCH_BITS-1:LO_BITS];
    oeWord = 32'h0000_0000;
    oeWord[OEM_BITS-1:0] = st.oeBits;
  end

  // read address decode; unmapped offsets read zero with an error
  always_comb
  begin
    readWord = 32'h0000_0000;
    readErr = 1'b0;
    if (paddr == `OMC_ARCH_LO_OFS)
      readWord = archLoWord;
    else if (paddr == `OMC_ARCH_HI_OFS)
      readWord = archHiWord;
    else if (paddr == `OMC_OE_MODE_OFS)
      readWord = oeWord;
    else if (paddr == `OMC_STATE_OFS)
    begin
      // stored q values low, synced pin levels high
      readWord[CELLS-1:0] = qState;
      readWord[`OMC_HI_FIELD_POS +: CELLS] = st.pinSync;
    end
    else if (paddr == `OMC_PIN_OFS)
    begin
      // driven levels low, active buffer enables high
      readWord[CELLS-1:0] = cellPinOut;
      readWord[`OMC_HI_FIELD_POS +: CELLS] = ~cellOeN;
    end
    else
      readErr = 1'b1;
  end

  // next state of the top: synchronisers, config writes, read capture
  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_st = st;
    // clock pins pass two flops before any edge logic
    next_st.clkASync = {st.clkASync[0], clockInputA};
    next_st.clkBSync = {st.clkBSync[0], clockInputB};
    next_st.clkAPrev = st.clkASync[1];
    next_st.clkBPrev = st.clkBSync[1];
    // io pin levels for feedback
    next_st.pinMeta = pinIn;
    next_st.pinSync = st.pinMeta;
    // capture answer in setup so prdata comes from a flop
    if (setupPhase)
    begin
      next_st.rdata = pwrite ? 32'h0000_0000 : readWord;
      next_st.slvErr = readErr;
    end
    // writes take effect at the access edge only
    if (accessWrite)
    begin
      if (paddr == `OMC_ARCH_LO_OFS)
      begin
        merged = mergeWord(archLoWord, pwdata, pstrb);
        next_st.archBits[LO_BITS-1:0] = merged;
      end
      else if (paddr == `OMC_ARCH_HI_OFS)
      begin
        merged = mergeWord(archHiWord, pwdata, pstrb);
        next_st.archBits[ARCH_BITS-1:LO_BITS] =
          merged[HI_BITS-1:0];
      end
      else if (paddr == `OMC_OE_MODE_OFS)
      begin
        merged = mergeWord(oeWord, pwdata, pstrb);
        next_st.oeBits = merged[OEM_BITS-1:0];
      end
      // read-only and unmapped offsets ignore writes
    end
    if (sysRst)
    begin
      // known configuration and cleared pipes after reset
      next_st.archBits = {CELLS{`OMC_ARCH_RST}};
      next_st.oeBits = {CELLS{`OMC_OEM_RST}};
      next_st.clkASync = 2'h0;
      next_st.clkBSync = 2'h0;
      next_st.clkAPrev = 1'b0;
      next_st.clkBPrev = 1'b0;
      next_st.pinMeta = '0;
      next_st.pinSync = '0;
      next_st.rdata = 32'h0000_0000;
      next_st.slvErr = 1'b0;
    end
  end

  // state register of the top
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  // one cell per output; term width differs from cell to cell
  // note: a clock pin edge is seen two to three mclk cycles late, and
  // pin clocks above half of mclk are missed; traded for safety
  genvar gi;
  generate
    for (gi = 0; gi < CELLS; gi++)
    begin : gCell
      omc_macrocell #(
        .TERMS(omc_term_count(gi))
      ) uCell (
        .mclk(mclk),
        .sysRst(sysRst),
        .terms(productTerms[omc_term_base(gi) +: omc_term_count(gi)]),
        .oeTerm(oeTerms[gi]),
        .arch(st.archBits[gi*`OMC_ARCH_W +: `OMC_ARCH_W]),
        .oeMode(omc_oe_t'(st.oeBits[gi*`OMC_OEM_W +: `OMC_OEM_W])),
        .edgeA(edgeA),
        .edgeB(edgeB),
        .asyncClearTerm(asyncClearTerm),
        .syncSetTerm(syncSetTerm),
        .pinSync(st.pinSync[gi]),
        .pinOut(cellPinOut[gi]),
        .pinOeN(cellOeN[gi]),
        .fbTrue(fbTrue[gi]),
        .fbInv(fbInv[gi]),
        .qState(qState[gi])
      );
    end
  endgenerate
endmodule : omc_macrocell_array

// ### tb/omc_board.sv
// board model: pin level resolution and clock pin pulses
`timescale 1ns/1ps
module omc_board (
  input wire logic mclk,
  input wire logic [11:0] pinOut,
  input wire logic [11:0] pinOeN,
  input wire logic [11:0] extLvl,
  output logic clockInputA,
  output logic clockInputB,
  output logic [11:0] pinIn
);
  // released pin shows the board level, else the cell drive
  always_comb
    pinIn = (pinOeN & extLvl) | (~pinOeN & pinOut);
  // clock pins idle low between pulses
  initial
  begin
    clockInputA = 1'b0;
    clockInputB = 1'b0;
  end
  // pulse kept 3 mclk wide, narrower pulses could lose edges in sync
  task automatic pulse(input logic selB);
    @(posedge mclk);
    clockInputA <= !selB;
    clockInputB <= selB;
    repeat (3) @(posedge mclk);
    clockInputA <= 1'b0;
    clockInputB <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : pulse
endmodule : omc_board

// ### tb/omc_properties.sv
// port checker for the macrocell array, cell 0 tracked
`timescale 1ns/1ps
module omc_checker #(
  parameter int TERMS_TOTAL = 136
) (
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic clockInputA,
  input wire logic [TERMS_TOTAL-1:0] productTerms,
  input wire logic [11:0] oeTerms,
  input wire logic asyncClearTerm,
  input wire logic syncSetTerm,
  input wire logic [11:0] fbTrue,
  input wire logic [11:0] fbInv,
  input wire logic [11:0] pinOut,
  input wire logic [11:0] pinOeN
);
  logic [3:0] a0; // cell 0 arch copy
  logic [1:0] m0; // cell 0 enable mode copy
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sysRst);
  // shadow copy; assumes full-word writes
  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      a0 <= 4'h2;
      m0 <= 2'h1;
    end
    else if (psel && penable && pwrite && paddr == 12'h000)
      a0 <= pwdata[3:0];
    else if (psel && penable && pwrite && paddr == 12'h008)
      m0 <= pwdata[1:0];
  end
  sequence s_set_edge;
    a0[0] && !a0[3] && $rose(clockInputA);
  endsequence
  sequence s_set_hold;
    (syncSetTerm && !asyncClearTerm)[*5];
  endsequence
  a_fb_pair: assert property (fbInv == ~fbTrue)
    else $error("feedback pair broken");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h010
    |-> pslverr) else $error("no error on unmapped");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  a_reg_oe: assert property (a0[0] |-> pinOeN[0] == !oeTerms[0])
    else $error("registered enable wrong");
  a_comb_oe: assert property (!a0[0] |-> pinOeN[0] == (m0 == 2'h0 ? 1'b0 :
    m0 == 2'h1 ? 1'b1 : !oeTerms[0])) else $error("enable mode wrong");
  a_clear_pin: assert property (a0[0] && asyncClearTerm |->
    pinOut[0] == !a0[1]) else $error("clear not seen at pin");
  a_comb_pin: assert property (!a0[0] |->
    pinOut[0] == ((|productTerms[7:0]) == a0[1])) else $error("sum wrong");
  a_preset_pin: assert property (s_set_edge ##0 s_set_hold |->
    pinOut[0] == a0[1]) else $error("preset missed");
endmodule : omc_checker
bind omc_macrocell_array omc_checker #(.TERMS_TOTAL(TERMS_TOTAL)) chk (
  .mclk(mclk), .sysRst(sysRst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .clockInputA(clockInputA),
  .productTerms(productTerms), .oeTerms(oeTerms),
  .asyncClearTerm(asyncClearTerm), .syncSetTerm(syncSetTerm),
  .fbTrue(fbTrue), .fbInv(fbInv), .pinOut(pinOut), .pinOeN(pinOeN));

// ### tb/omc_macrocell_array_tb_top.sv
// self-checking bench for the output macrocell array
`timescale 1ns/1ps
module omc_macrocell_array_tb_top;
  logic mclk, sysRst, psel, penable, pwrite, pslverr, pready, e;
  logic [11:0] paddr, oeT, fbT, fbI, pinIn, pinOut, pinOeN, ext;
  logic [31:0] pwdata, prdata, r;
  logic [135:0] pt; // flat logic terms
  logic clr, set, ckA, ckB;
  logic [3:0] strb; // apb byte strobes
  int errors, samplesChecked, cyc;
  int cnt[12] = '{8, 8, 10, 12, 14, 16, 16, 14, 12, 10, 8, 8};
  omc_macrocell_array dut (.mclk(mclk), .sysRst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clockInputA(ckA), .clockInputB(ckB), .productTerms(pt),
    .oeTerms(oeT), .asyncClearTerm(clr), .syncSetTerm(set),
    .fbTrue(fbT), .fbInv(fbI), .pinIn(pinIn), .pinOut(pinOut),
    .pinOeN(pinOeN));
  omc_board board (.mclk(mclk), .pinOut(pinOut), .pinOeN(pinOeN),
    .extLvl(ext), .clockInputA(ckA), .clockInputB(ckB), .pinIn(pinIn));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, entered just after an edge; idles one edge after
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(r, x);
  endtask : rd
  // reset values, read-only and unmapped places
  task automatic t_reset();
    rd(12'h000, 32'h22222222);
    rd(12'h004, 32'h00002222);
    rd(12'h008, 32'h00555555);
    wr(12'h00c, 32'hffffffff);
    rd(12'h00c, 32'h0fff0000);
    rd(12'h014, 32'h0);
    check(32'(e), 32'h1);
    check(32'(pready), 32'h1);
    // one byte lane only: cell 8 and 9 nibbles change, the rest kept
    strb <= 4'h1;
    wr(12'h004, 32'h11111133);
    strb <= 4'hf;
    rd(12'h004, 32'h00002233);
    wr(12'h004, 32'h00002222);
    check(32'(pinOeN), 32'hfff);
  endtask : t_reset
  // last term of each cell lights only that cell
  task automatic t_terms();
    int b;
    b = 0;
    wr(12'h008, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      pt <= 136'h1 << (b + cnt[i] - 1);
      b = b + cnt[i];
      @(negedge mclk);
      check(32'(pinOut), 32'h1 << i);
      @(posedge mclk);
    end
    pt <= '0;
    wr(12'h000, 32'h0);
    check(32'(pinOut[7:0]), 32'hff);
    wr(12'h008, 32'h00aaaaaa);
    oeT <= 12'h5a5;
    @(negedge mclk);
    check(32'(pinOeN), 32'ha5a);
    @(posedge mclk);
    rd(12'h010, 32'h05a500ff);
    wr(12'h000, 32'h6);
    wr(12'h008, 32'h1);
    ext <= 12'hffe;
    repeat (4) @(posedge mclk);
    check(32'(fbT[0]), 32'h0);
  endtask : t_terms
  // registered cell 0: clocks, clear, preset, polarity, buried reg
  task automatic t_reg();
    oeT <= 12'h001;
    wr(12'h000, 32'h3);
    pt <= 136'h1;
    board.pulse(1'b0);
    check(32'({pinOut[0], fbT[0], fbI[0], pinOeN[0]}), 32'ha);
    rd(12'h00c, 32'h00ff0001);
    pt <= '0;
    board.pulse(1'b1);
    check(32'(pinOut[0]), 32'h1);
    clr <= 1'b1;
    @(negedge mclk);
    check(32'(pinOut[0]), 32'h0);
    @(posedge mclk);
    {clr, set} <= 2'h1;
    board.pulse(1'b0);
    check(32'(pinOut[0]), 32'h1);
    wr(12'h000, 32'h1);
    check(32'(pinOut[0]), 32'h0);
    clr <= 1'b1;
    board.pulse(1'b0);
    check(32'(pinOut[0]), 32'h1);
    {clr, set} <= 2'h0;
    wr(12'h000, 32'hb);
    pt <= 136'h1;
    board.pulse(1'b1);
    check(32'(pinOut[0]), 32'h1);
    pt <= '0;
    wr(12'h000, 32'h2);
    board.pulse(1'b0);
    check(32'(fbT[0]), 32'h1);
  endtask : t_reg
  // reset in mid-run clears stored values and reloads the reset configuration
  task automatic t_rerun();
    wr(12'h000, 32'h3);
    pt <= 136'h1;
    board.pulse(1'b0);
    check(32'(pinOut[0]), 32'h1);
    sysRst <= 1'b1;
    repeat (3) @(posedge mclk);
    sysRst <= 1'b0;
    rd(12'h00c, 32'h0);
    rd(12'h000, 32'h22222222);
    check(32'(pinOeN), 32'hfff);
    pt <= '0;
  endtask : t_rerun
  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // hang guard, run needs well under 1000 cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      give_verdict();
    end
  end
  initial
  begin
    {sysRst, psel, penable, pwrite, clr, set} = 6'h20;
    {paddr, oeT, pwdata, pt} = '0;
    ext = 12'hfff;
    strb = 4'hf;
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    t_reset();
    t_terms();
    t_reg();
    t_rerun();
    give_verdict();
  end
endmodule : omc_macrocell_array_tb_top
